// ---- dv/scjcp_config_port_asserts.sv ----
// Timing checks on the configuration port pins
`timescale 1ns/1ns
module scjcp_config_port_asserts #(
   parameter int POWERUP_CYCLES = 100,
   parameter int BITSTREAM_BYTES = 4
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Configuration pins
   input wire logic CONFIG_START_N,
   input wire logic CONFIG_STATUS_N_OUT,
   input wire logic CONFIG_STATUS_N_OE,
   input wire logic CONFIG_COMPLETE,
   input wire logic INIT_CLK_SELECT,
   input wire logic USER_INIT_CLOCK,
   // Test port and core side
   input wire logic TCK,
   input wire logic TDO,
   input wire logic TDO_OE,
   input wire logic USER_MODE,
   input wire logic USER_IO_HIZ,
   input wire logic CFG_BYTE_VALID
);
   // 800 ns in CLK cycles
   localparam int T_LOW = 200;
   // Armed from start release until status drive drops
   logic armed;
   logic [13:0] rel_cnt;
   // Complete-to-user cycles and user clock rises
   logic [12:0] cd_cnt;
   logic [7:0] uc_cnt;
   // User clock pin delayed like the three-stage input filter
   logic [3:0] uc_d;
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // Release timer; saturates so a stuck drive cannot wrap it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         armed <= 1'b0;
         rel_cnt <= 14'h0;
      end else if ($rose(CONFIG_START_N)) begin
         armed <= 1'b1;
         rel_cnt <= 14'h0;
      end else begin
         armed <= armed && CONFIG_STATUS_N_OE;
         rel_cnt <= rel_cnt + {13'h0, armed && rel_cnt != 14'h3fff};
      end
   end
   // Delay line so counted user clock rises line up with the filtered ones
   always_ff @(posedge CLK) begin
      uc_d <= {uc_d[2:0], USER_INIT_CLOCK};
   end
   // Init timers run only while complete is high
   always_ff @(posedge CLK) begin
      if (SRST || !CONFIG_COMPLETE) begin
         cd_cnt <= 13'h0;
         uc_cnt <= 8'h0;
      end else if (!USER_MODE) begin
         cd_cnt <= cd_cnt + {12'h0, cd_cnt != 13'h1fff};
         uc_cnt <= uc_cnt + {7'h0, uc_d[2] && !uc_d[3] && uc_cnt != 8'hff};
      end
   end
   // Start request seen at the pin
   sequence s_start_fall;
      $fell(CONFIG_START_N);
   endsequence
   property p_done_low; s_start_fall |-> ##[1:T_LOW] (!CONFIG_COMPLETE)[*8]; endproperty
   property p_stat_low; s_start_fall |-> ##[1:T_LOW] (CONFIG_STATUS_N_OE && !CONFIG_STATUS_N_OUT)[*8]; endproperty
   property p_release; armed |-> rel_cnt < 14'd10000; endproperty
   property p_pulse_min; armed && $fell(CONFIG_STATUS_N_OE) |-> rel_cnt >= 14'd2500; endproperty
   property p_user_int; $rose(USER_MODE) && !INIT_CLK_SELECT |-> cd_cnt >= 13'd1500 && cd_cnt <= 13'd5000; endproperty
   property p_user_clk; $rose(USER_MODE) && INIT_CLK_SELECT |-> uc_cnt == 8'd140; endproperty
   property p_done_cause; $rose(CONFIG_COMPLETE) |-> CFG_BYTE_VALID; endproperty
   property p_hiz; USER_IO_HIZ != USER_MODE; endproperty
   property p_tdo_fall; $changed(TDO) || $changed(TDO_OE) |-> !$past(TCK) && !$past(TCK, 2); endproperty
   a_done_low: assert property (p_done_low) else $error("complete not low after start");
   a_stat_low: assert property (p_stat_low) else $error("status not pulled low");
   a_release: assert property (p_release) else $error("status held too long");
   a_pulse_min: assert property (p_pulse_min) else $error("status pulse too short");
   a_user_int: assert property (p_user_int) else $error("internal init time off");
   a_user_clk: assert property (p_user_clk) else $error("user clock init count off");
   a_done_cause: assert property (p_done_cause) else $error("complete without last byte");
   a_hiz: assert property (p_hiz) else $error("user pins not tristated");
   a_tdo_fall: assert property (p_tdo_fall) else $error("TDO moved off falling edge");
endmodule : scjcp_config_port_asserts

bind scjcp_config_port scjcp_config_port_asserts #(
   .POWERUP_CYCLES(POWERUP_CYCLES), .BITSTREAM_BYTES(BITSTREAM_BYTES)) u_chk (
   .CLK(CLK), .SRST(SRST), .CONFIG_START_N(CONFIG_START_N), .CONFIG_STATUS_N_OUT(CONFIG_STATUS_N_OUT),
   .CONFIG_STATUS_N_OE(CONFIG_STATUS_N_OE), .CONFIG_COMPLETE(CONFIG_COMPLETE), .INIT_CLK_SELECT(INIT_CLK_SELECT),
   .USER_INIT_CLOCK(USER_INIT_CLOCK), .TCK(TCK), .TDO(TDO), .TDO_OE(TDO_OE), .USER_MODE(USER_MODE),
   .USER_IO_HIZ(USER_IO_HIZ), .CFG_BYTE_VALID(CFG_BYTE_VALID));

// ---- dv/scjcp_config_port_tb_top.sv ----
// Self-checking bench for the configuration port
`timescale 1ns/1ns
module scjcp_config_port_tb_top;
   // Stimulus and observed pins
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sel = 1'b0;
   logic uclk = 1'b0;
   logic uclk_run = 1'b0;
   logic [2:0] udiv = 3'h0;
   logic tck = 1'b0;
   logic tms = 1'b1;
   logic tdi = 1'b1;
   logic start_n, sclk, sdata, status_n, st_out, st_oe, done, tdo, tdo_oe, user, hiz, vld;
   logic [7:0] cfg_byte;
   logic tdo_seen, oe_seen;
   int n_mismatch = 0;
   int comparisons = 0;
   bit ok;
   // Open-drain status wire with pull-up
   assign status_n = !(st_oe && !st_out);
   always #2 clk = ~clk;
   // User init clock, 48 ns period once enabled
   always @(posedge clk) begin
      udiv <= (udiv == 3'h5) ? 3'h0 : udiv + 3'h1;
      if (uclk_run && udiv == 3'h5) uclk <= ~uclk;
   end
   scjcp_host_model host (.clk(clk), .status_n(status_n), .start_n(start_n), .sclk(sclk), .sdata(sdata));
   scjcp_config_port #(.POWERUP_CYCLES(100), .BITSTREAM_BYTES(4)) dut (
      .CLK(clk), .SRST(srst), .CONFIG_START_N(start_n), .CONFIG_STATUS_N_IN(status_n),
      .CONFIG_STATUS_N_OUT(st_out), .CONFIG_STATUS_N_OE(st_oe), .CONFIG_COMPLETE(done),
      .INIT_CLK_SELECT(sel), .USER_INIT_CLOCK(uclk), .SERIAL_CONFIG_CLOCK(sclk),
      .SERIAL_CONFIG_DATA(sdata), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
      .USER_MODE(user), .USER_IO_HIZ(hiz), .CFG_BYTE(cfg_byte), .CFG_BYTE_VALID(vld));
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Verdict and stop
   task automatic end_sim;
      $display("Counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   // Bounded wait: 0 byte valid, 1 complete, 2 user mode
   task automatic wait_for(input int w, input int lim);
      for (int n = 0; n <= lim; n++) begin
         @(posedge clk);
         if ((w == 0 && vld === 1'b1) || (w == 1 && done === 1'b1) || (w == 2 && user === 1'b1)) return;
      end
      check(8'h0, 8'h1);
      end_sim();
   endtask : wait_for
   // Send one byte and compare what arrives
   task automatic link_byte(input logic [7:0] b, input int pause_ns);
      host.send_byte(b, pause_ns);
      wait_for(0, 20);
      check(cfg_byte, b);
   endtask : link_byte
   // One test clock, TDO read after the falling edge lands
   task automatic tap(input logic m, input logic d);
      @(posedge clk);
      tms <= m;
      tdi <= d;
      repeat (8) @(posedge clk);
      tck <= 1'b1;
      repeat (8) @(posedge clk);
      tck <= 1'b0;
      repeat (8) @(posedge clk);
      tdo_seen = tdo;
      oe_seen = tdo_oe;
   endtask : tap
   // Power-up hold
   task automatic t_powerup;
      repeat (90) @(posedge clk);
      check({7'h00, st_oe}, 8'h01);
      check({7'h00, done}, 8'h00);
      $display("Test powerup finished");
   endtask : t_powerup
   // Good stream with a paused byte, internal init
   task automatic t_serial;
      host.restart(ok);
      check({7'h00, ok}, 8'h01);
      link_byte(8'h5a, 0);
      link_byte(8'h81, 2000);
      link_byte(8'h3c, 0);
      link_byte(8'he7, 0);
      check({7'h00, done}, 8'h01);
      check({7'h00, hiz}, 8'h01);
      wait_for(2, 5200);
      check({7'h00, user}, 8'h01);
      $display("Test serial finished");
   endtask : t_serial
   // Test port program aborts a partial serial stream
   task automatic t_jtag;
      logic [31:0] s;
      logic [15:0] mseq; // TMS per test clock
      logic [15:0] dseq; // TDI per test clock
      s = 32'h960fa53c;
      mseq = 16'h60df;
      dseq = 16'h0800;
      // user clock kept running through the start pulse
      sel <= 1'b1;
      uclk_run <= 1'b1;
      host.restart(ok);
      check({7'h00, ok}, 8'h01);
      link_byte(8'h11, 0);
      link_byte(8'h22, 0);
      // Reset by TMS, then load program instruction
      for (int i = 0; i < 16; i++) tap(mseq[i], dseq[i]);
      check({7'h00, done}, 8'h00);
      check({7'h00, oe_seen}, 8'h00);
      tap(1'b1, 1'b0);
      tap(1'b0, 1'b0);
      tap(1'b0, 1'b0);
      check({7'h00, oe_seen}, 8'h01);
      for (int i = 0; i < 32; i++) begin
         tap(i == 31, s[i]);
         if (i < 31) check({6'h00, tdo_seen, oe_seen}, {6'h00, s[i], 1'b1});
      end
      check({7'h00, oe_seen}, 8'h00);
      // Last program byte is the top byte of the stream
      check(cfg_byte, s[31:24]);
      tap(1'b1, 1'b0);
      tap(1'b0, 1'b0);
      check({7'h00, done}, 8'h01);
      check({7'h00, hiz}, 8'h01);
      wait_for(2, 2000);
      check({7'h00, user}, 8'h01);
      for (int i = 0; i < 5; i++) tap(1'b1, 1'b1);
      uclk_run <= 1'b0;
      sel <= 1'b0;
      $display("Test jtag finished");
   endtask : t_jtag
   // Bad checksum leaves status pulled low
   task automatic t_error;
      host.restart(ok);
      check({7'h00, ok}, 8'h01);
      link_byte(8'h01, 0);
      link_byte(8'h02, 0);
      link_byte(8'h04, 0);
      link_byte(8'h00, 0);
      repeat (3000) @(posedge clk);
      check({6'h00, done, st_oe}, 8'h01);
      $display("Test error finished");
   endtask : t_error
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_powerup();
      t_serial();
      t_jtag();
      t_error();
      end_sim();
   end
endmodule : scjcp_config_port_tb_top

// ---- dv/scjcp_host_model.sv ----
// Host model driving the serial configuration pins
`timescale 1ns/1ns
module scjcp_host_model (
   // Pacing clock
   input wire logic clk,
   // Status wire level
   input wire logic status_n,
   // Pins toward the device
   output logic start_n,
   output logic sclk,
   output logic sdata
);
   // Start released, link clock parked
   initial begin
      start_n = 1'b1;
      sclk = 1'b0;
      sdata = 1'b0;
   end
   // Pulse start, then wait until clocking is allowed
   task automatic restart(output bit ok);
      int n;
      n = 0;
      @(posedge clk);
      start_n <= 1'b0;
      repeat (10000) @(posedge clk);
      start_n <= 1'b1;
      while (status_n !== 1'b1 && n < 12000) begin
         @(posedge clk);
         n++;
      end
      ok = (status_n === 1'b1);
      repeat (250) @(posedge clk);
      if (n < 9750) repeat (9750 - n) @(posedge clk);
   endtask : restart
   // LSB first, 15 ns period, optional pause
   task automatic send_byte(input logic [7:0] b, input int pause_ns);
      // Odd offset keeps the byte toggle clear of system clock edges
      #1;
      for (int i = 0; i < 8; i++) begin
         sdata = b[i];
         #7 sclk = 1'b1;
         #8 sclk = 1'b0;
         if (i == 3) #(pause_ns);
      end
      // clock parked, data kept at a defined level
      sdata = ~b[7];
   endtask : send_byte
endmodule : scjcp_host_model

// ---- hw/scjcp_config_port.sv ----
// Serial and JTAG configuration entry logic with its serial receiver
`timescale 1ns/1ns
module scjcp_link_rx (
   // Link clock and data
   input wire logic lclk,
   input wire logic data,
   // Enable level from the system domain
   input wire logic en,
   // Byte toward the system domain
   output logic [7:0] word,
   output logic tog
);
   // Link side state
   typedef struct packed {
      logic [2:0] bcnt; // Bits in current byte
      logic [7:0] sh;   // Shift register
      logic [7:0] word; // Last whole byte
      logic tog;        // Flips once per byte
   } scjcp_rx_t;

   scjcp_rx_t r;
   scjcp_rx_t next_r;

   // Byte assembly
   always_comb begin
      next_r = r;
      next_r.sh = {data, r.sh[7:1]};
      next_r.bcnt = r.bcnt + 3'h1;
      if (r.bcnt == 3'h7) begin
         next_r.word = {data, r.sh[7:1]};
         next_r.tog = ~r.tog;
      end
   end

   // Enable low clears at once; the link clock may be idle then
   // Rising edge capture
   always_ff @(posedge lclk or negedge en) begin
      if (!en) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Word stays stable for eight link clocks after each flip
   assign word = r.word;
   assign tog = r.tog;
endmodule : scjcp_link_rx

module scjcp_config_port #(
   parameter int POWERUP_CYCLES = scjcp_pkg::POWERUP_CYC,
   parameter int BITSTREAM_BYTES = scjcp_pkg::STREAM_BYTES
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Configuration pins
   input wire logic CONFIG_START_N,
   input wire logic CONFIG_STATUS_N_IN,
   output logic CONFIG_STATUS_N_OUT,
   output logic CONFIG_STATUS_N_OE,
   output logic CONFIG_COMPLETE,
   input wire logic INIT_CLK_SELECT,
   input wire logic USER_INIT_CLOCK,
   // Serial link
   input wire logic SERIAL_CONFIG_CLOCK,
   input wire logic SERIAL_CONFIG_DATA,
   // Test port
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE,
   // Core side
   output logic USER_MODE,
   output logic USER_IO_HIZ,
   output logic [7:0] CFG_BYTE,
   output logic CFG_BYTE_VALID
);
   // All system domain state
   typedef struct packed {
      logic [scjcp_pkg::NSYNC-1:0] s0; // First sync stage
      logic [scjcp_pkg::NSYNC-1:0] s1; // Second stage
      logic [scjcp_pkg::NSYNC-1:0] s2; // Third stage
      logic [scjcp_pkg::NSYNC-1:0] f;  // Filtered levels
      scjcp_pkg::scjcp_cfg_t st;       // Sequence state
      logic [scjcp_pkg::CNT_W-1:0] cnt; // Time counter
      logic [7:0] ucnt;                // User clock edges
      logic [15:0] nbytes;             // Bytes taken
      logic [7:0] csum;                // Running xor
      logic seen;                      // Last toggle taken
      scjcp_pkg::scjcp_tap_t tap;      // TAP state
      logic [3:0] ir;                  // Instruction
      logic [3:0] ir_sh;               // Instruction shifter
      logic [7:0] jsh;                 // Program byte shifter
      logic [2:0] jcnt;                // Program bit count
      logic byp;                       // Bypass bit
      logic en;                        // Serial receive enable
      logic stat_o;                    // Status drive level
      logic stat_oe;                   // Status pulled low
      logic done;                      // Complete output
      logic user;                      // User mode
      logic hiz;                       // User pins tristated
      logic tdo;                       // Test data out
      logic tdo_oe;                    // Test data enable
      logic [7:0] byte_o;              // Byte to core
      logic byte_v;                    // Byte strobe
   } scjcp_st_t;

   scjcp_st_t r;
   scjcp_st_t next_r;
   logic [7:0] rx_word; // Receiver byte
   logic rx_tog;        // Receiver toggle

   // Serial receiver on the link clock
   scjcp_link_rx u_rx (
      .lclk(SERIAL_CONFIG_CLOCK),
      .data(SERIAL_CONFIG_DATA),
      .en(r.en),
      .word(rx_word),
      .tog(rx_tog)
   );

   // TAP transition on TMS
   function automatic scjcp_pkg::scjcp_tap_t tap_next(
      input scjcp_pkg::scjcp_tap_t s,
      input logic m
   );
      case (s)
         scjcp_pkg::TP_TLR: tap_next = m ? scjcp_pkg::TP_TLR : scjcp_pkg::TP_RTI;
         scjcp_pkg::TP_RTI: tap_next = m ? scjcp_pkg::TP_SEL_DR : scjcp_pkg::TP_RTI;
         scjcp_pkg::TP_SEL_DR: tap_next = m ? scjcp_pkg::TP_SEL_IR : scjcp_pkg::TP_CAP_DR;
         scjcp_pkg::TP_CAP_DR: tap_next = m ? scjcp_pkg::TP_EX1_DR : scjcp_pkg::TP_SH_DR;
         scjcp_pkg::TP_SH_DR: tap_next = m ? scjcp_pkg::TP_EX1_DR : scjcp_pkg::TP_SH_DR;
         scjcp_pkg::TP_EX1_DR: tap_next = m ? scjcp_pkg::TP_UP_DR : scjcp_pkg::TP_PA_DR;
         scjcp_pkg::TP_PA_DR: tap_next = m ? scjcp_pkg::TP_EX2_DR : scjcp_pkg::TP_PA_DR;
         scjcp_pkg::TP_EX2_DR: tap_next = m ? scjcp_pkg::TP_UP_DR : scjcp_pkg::TP_SH_DR;
         scjcp_pkg::TP_UP_DR: tap_next = m ? scjcp_pkg::TP_SEL_DR : scjcp_pkg::TP_RTI;
         scjcp_pkg::TP_SEL_IR: tap_next = m ? scjcp_pkg::TP_TLR : scjcp_pkg::TP_CAP_IR;
         scjcp_pkg::TP_CAP_IR: tap_next = m ? scjcp_pkg::TP_EX1_IR : scjcp_pkg::TP_SH_IR;
         scjcp_pkg::TP_SH_IR: tap_next = m ? scjcp_pkg::TP_EX1_IR : scjcp_pkg::TP_SH_IR;
         scjcp_pkg::TP_EX1_IR: tap_next = m ? scjcp_pkg::TP_UP_IR : scjcp_pkg::TP_PA_IR;
         scjcp_pkg::TP_PA_IR: tap_next = m ? scjcp_pkg::TP_EX2_IR : scjcp_pkg::TP_PA_IR;
         scjcp_pkg::TP_EX2_IR: tap_next = m ? scjcp_pkg::TP_UP_IR : scjcp_pkg::TP_SH_IR;
         scjcp_pkg::TP_UP_IR: tap_next = m ? scjcp_pkg::TP_SEL_DR : scjcp_pkg::TP_RTI;
         default: tap_next = scjcp_pkg::TP_TLR;
      endcase
   endfunction : tap_next

   // Next state of everything
   always_comb begin
      logic [scjcp_pkg::NSYNC-1:0] fn; // New filtered levels
      logic [scjcp_pkg::NSYNC-1:0] rise;
      logic [scjcp_pkg::NSYNC-1:0] fall;
      logic nb_v; // A byte arrived
      logic [7:0] nb;
      fn = '0;
      rise = '0;
      fall = '0;
      nb_v = 1'b0;
      nb = 8'h00;
      next_r = r;
      next_r.byte_v = 1'b0;
      // Pin sampling; a change counts once stages two and three agree
      next_r.s0 = {rx_tog, TDI, TMS, TCK, INIT_CLK_SELECT, USER_INIT_CLOCK,
                   CONFIG_STATUS_N_IN, CONFIG_START_N};
      next_r.s1 = r.s0;
      next_r.s2 = r.s1;
      fn = (~(r.s1 ^ r.s2) & r.s2) | ((r.s1 ^ r.s2) & r.f);
      next_r.f = fn;
      rise = fn & ~r.f;
      fall = ~fn & r.f;

      if (rise[scjcp_pkg::I_TCK]) begin
         next_r.tap = tap_next(r.tap, fn[scjcp_pkg::I_TMS]);
         case (r.tap)
            scjcp_pkg::TP_TLR: begin
               next_r.ir = scjcp_pkg::IR_BYPASS;
            end
            scjcp_pkg::TP_CAP_IR: begin
               next_r.ir_sh = scjcp_pkg::IR_CAPTURE;
            end
            scjcp_pkg::TP_SH_IR: begin
               next_r.ir_sh = {fn[scjcp_pkg::I_TDI], r.ir_sh[3:1]};
            end
            scjcp_pkg::TP_UP_IR: begin
               next_r.ir = r.ir_sh;
               if (r.ir_sh == scjcp_pkg::IR_PROGRAM) begin
                  next_r.st = scjcp_pkg::CS_JTAG;
                  next_r.nbytes = 16'h0000;
                  next_r.csum = 8'h00;
                  next_r.jcnt = 3'h0;
               end
            end
            scjcp_pkg::TP_CAP_DR: begin
               next_r.byp = 1'b0;
            end
            scjcp_pkg::TP_SH_DR: begin
               next_r.byp = fn[scjcp_pkg::I_TDI];
               // Program data assembled low bit first
               if (r.ir == scjcp_pkg::IR_PROGRAM && r.st == scjcp_pkg::CS_JTAG) begin
                  next_r.jsh = {fn[scjcp_pkg::I_TDI], r.jsh[7:1]};
                  next_r.jcnt = r.jcnt + 3'h1;
                  if (r.jcnt == 3'h7) begin
                     nb_v = 1'b1;
                     nb = {fn[scjcp_pkg::I_TDI], r.jsh[7:1]};
                  end
               end
            end
            default: begin
               // Other states hold the registers
            end
         endcase
      end

      if (fall[scjcp_pkg::I_TCK]) begin
         next_r.tdo_oe = (r.tap == scjcp_pkg::TP_SH_DR) || (r.tap == scjcp_pkg::TP_SH_IR);
         next_r.tdo = (r.tap == scjcp_pkg::TP_SH_IR) ? r.ir_sh[0] : r.byp;
      end

      // Serial byte crossing, word is stable long before the next flip
      if (r.st == scjcp_pkg::CS_CONFIG && fn[scjcp_pkg::I_TOG] != r.seen) begin
         next_r.seen = fn[scjcp_pkg::I_TOG];
         nb_v = 1'b1;
         nb = rx_word;
      end
      if (r.st != scjcp_pkg::CS_CONFIG) begin
         next_r.seen = 1'b0;
      end

      // Byte intake, last byte is the xor of all before it
      if (nb_v) begin
         next_r.byte_o = nb;
         next_r.byte_v = 1'b1;
         next_r.nbytes = r.nbytes + 16'h0001;
         next_r.csum = r.csum ^ nb;
         if (r.nbytes == 16'(BITSTREAM_BYTES - 1)) begin
            next_r.cnt = '0;
            next_r.ucnt = 8'h00;
            next_r.st = (nb == r.csum) ? scjcp_pkg::CS_INIT : scjcp_pkg::CS_ERROR;
         end
      end

      // Sequence of the configuration pins
      case (r.st)
         scjcp_pkg::CS_POWERUP: begin
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == scjcp_pkg::CNT_W'(POWERUP_CYCLES - 1)) begin
               next_r.cnt = '0;
               next_r.st = fn[scjcp_pkg::I_START] ? scjcp_pkg::CS_HOLD : scjcp_pkg::CS_RESET;
            end
         end
         scjcp_pkg::CS_RESET: begin
            next_r.cnt = '0;
            if (fn[scjcp_pkg::I_START]) begin
               next_r.st = scjcp_pkg::CS_HOLD;
            end
         end
         scjcp_pkg::CS_HOLD: begin
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == scjcp_pkg::CNT_W'(scjcp_pkg::STATUS_CYC - 1)) begin
               next_r.st = scjcp_pkg::CS_WAIT_HI;
            end
         end
         // Another party may still hold status low
         scjcp_pkg::CS_WAIT_HI: begin
            if (fn[scjcp_pkg::I_STAT]) begin
               next_r.st = scjcp_pkg::CS_CONFIG;
               next_r.nbytes = 16'h0000;
               next_r.csum = 8'h00;
            end
         end
         scjcp_pkg::CS_INIT: begin
            next_r.cnt = r.cnt + 1'b1;
            if (rise[scjcp_pkg::I_UCLK]) begin
               next_r.ucnt = r.ucnt + 8'h01;
            end
            if (fn[scjcp_pkg::I_SEL]) begin
               if (rise[scjcp_pkg::I_UCLK] && r.ucnt == scjcp_pkg::USER_INIT_PERIODS - 8'h01) begin
                  next_r.st = scjcp_pkg::CS_USER;
               end
            end else if (r.cnt == scjcp_pkg::CNT_W'(scjcp_pkg::INIT_CYC - 1)) begin
               next_r.st = scjcp_pkg::CS_USER;
            end
         end
         default: begin
            // Config, user, error and JTAG wait on events
         end
      endcase

      // Start low restarts
      // JTAG takes precedence over the start pin
      if (!fn[scjcp_pkg::I_START] && r.st != scjcp_pkg::CS_JTAG && r.st != scjcp_pkg::CS_POWERUP) begin
         next_r.st = scjcp_pkg::CS_RESET;
      end

      // Outputs follow the next state so they align with it
      next_r.en = (next_r.st == scjcp_pkg::CS_CONFIG);
      next_r.stat_oe = (next_r.st == scjcp_pkg::CS_POWERUP) || (next_r.st == scjcp_pkg::CS_RESET) ||
                       (next_r.st == scjcp_pkg::CS_HOLD) || (next_r.st == scjcp_pkg::CS_ERROR);
      next_r.stat_o = 1'b0;
      next_r.done = (next_r.st == scjcp_pkg::CS_INIT) || (next_r.st == scjcp_pkg::CS_USER);
      next_r.user = (next_r.st == scjcp_pkg::CS_USER);
      next_r.hiz = (next_r.st != scjcp_pkg::CS_USER);
   end

   // State register
   always_ff @(posedge CLK) begin
      if (SRST) begin
         r <= '0;
         r.f <= '1;
         r.st <= scjcp_pkg::CS_POWERUP;
         r.tap <= scjcp_pkg::TP_TLR;
         r.ir <= scjcp_pkg::IR_BYPASS;
         r.stat_oe <= 1'b1;
         r.hiz <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign CONFIG_STATUS_N_OUT = r.stat_o;
   assign CONFIG_STATUS_N_OE = r.stat_oe;
   assign CONFIG_COMPLETE = r.done;
   assign TDO = r.tdo;
   assign TDO_OE = r.tdo_oe;
   assign USER_MODE = r.user;
   assign USER_IO_HIZ = r.hiz;
   assign CFG_BYTE = r.byte_o;
   assign CFG_BYTE_VALID = r.byte_v;
endmodule : scjcp_config_port

// ---- hw/scjcp_pkg.sv ----
// Constants and types for the serial and JTAG configuration port
// Operation
// - Start low drives complete low within 800 ns
// - Start low pulls status low within 800 ns; during JTAG configuration start is ignored
// - Status released within 40 us after start rises
// - Status low pulse lasts 10 to 40 us
// - Serial data captured on serial clock rising
// - Internal init reaches user mode 6-20 us
// - User clock init takes 140 periods
// - Status held low about 100 ms at power-up
// - Complete stays low until configuration completes
// - JTAG configuration aborts serial configuration
// - Test port has four pins, no TRST
// - User pins tristated during JTAG configuration
// - TDI sampled on TCK rising edge
// - TDO updated on falling, tristated when idle
// - TAP evaluates TMS on TCK rising
// - Detected error pulls status low
// - Serial clock may pause; reception resumes correctly
package scjcp_pkg;
   // System clock rate
   localparam int CLK_MHZ = 250;
   // Minimum status low pulse
   localparam int T_STATUS_MIN_NS = 10000;
   localparam int STATUS_CYC = (T_STATUS_MIN_NS * CLK_MHZ + 999) / 1000;
   // Minimum delay from complete to user mode
   localparam int T_CD2UM_MIN_NS = 6000;
   localparam int INIT_CYC = (T_CD2UM_MIN_NS * CLK_MHZ + 999) / 1000;
   // Power-up status hold
   localparam int T_POWERUP_MS = 100;
   localparam int POWERUP_CYC = T_POWERUP_MS * 1000 * CLK_MHZ;
   // User clock periods of initialization
   localparam logic [7:0] USER_INIT_PERIODS = 8'h8c;
   // Counter width, holds the power-up count
   localparam int CNT_W = 25;
   // Default stream length in bytes
   localparam int STREAM_BYTES = 16;
   // Synchroniser lane positions
   localparam int NSYNC = 8;
   localparam int I_START = 0;
   localparam int I_STAT = 1;
   localparam int I_UCLK = 2;
   localparam int I_SEL = 3;
   localparam int I_TCK = 4;
   localparam int I_TMS = 5;
   localparam int I_TDI = 6;
   localparam int I_TOG = 7;
   // Instruction register
   localparam logic [3:0] IR_BYPASS = 4'hf;
   localparam logic [3:0] IR_PROGRAM = 4'h2;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   // Configuration sequence states
   typedef enum logic [3:0] {
      CS_POWERUP, CS_RESET, CS_HOLD, CS_WAIT_HI, CS_CONFIG,
      CS_INIT, CS_USER, CS_ERROR, CS_JTAG
   } scjcp_cfg_t;
   // Test access port states
   typedef enum logic [3:0] {
      TP_TLR, TP_RTI, TP_SEL_DR, TP_CAP_DR, TP_SH_DR, TP_EX1_DR, TP_PA_DR, TP_EX2_DR,
      TP_UP_DR, TP_SEL_IR, TP_CAP_IR, TP_SH_IR, TP_EX1_IR, TP_PA_IR, TP_EX2_IR, TP_UP_IR
   } scjcp_tap_t;
endpackage : scjcp_pkg
